// ### logic/dtc_pkg.sv
// shared constants and types for the dual timer/counter control block
package dtc_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_IRQ_CTRL = 8'h88;
  localparam logic [7:0] IDX_MODE_SEL = 8'h89;
  localparam logic [7:0] IDX_CNT_LO_A = 8'h8A;
  localparam logic [7:0] IDX_CNT_LO_B = 8'h8B;
  localparam logic [7:0] IDX_CNT_HI_A = 8'h8C;
  localparam logic [7:0] IDX_CNT_HI_B = 8'h8D;
  localparam logic [7:0] IDX_CLK_RATE = 8'h8E;

  // register word layout
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_W = 8;
  localparam int unsigned REG_W = 8;
  localparam int unsigned DATA_W = 32;

  // reset values
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_SEL_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [2:0] RAM_STRETCH_RST = 3'h1;

  // clock rate register fields
  localparam int unsigned RATE_B_BIT = 4;
  localparam int unsigned RATE_A_BIT = 3;
  localparam int unsigned STRETCH_MSB = 2;
  localparam int unsigned CLK_RATE_W = 5;

  // 13-bit mode uses this many low-byte bits
  localparam int unsigned CNT13_LO_W = 5;

  // prescaler divide ratios of the cpu clock
  localparam int unsigned PRESC_W = 4;
  localparam logic [3:0] DIV_SLOW = 4'hC;
  localparam logic [3:0] DIV_FAST = 4'h4;

  // external pin vector positions
  localparam int unsigned PIN_IRQ_A = 0;
  localparam int unsigned PIN_IRQ_B = 1;
  localparam int unsigned PIN_CNT_A = 2;
  localparam int unsigned PIN_CNT_B = 3;
  localparam int unsigned PIN_N = 4;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'h0,
    MODE_16BIT = 2'h1,
    MODE_8RELOAD = 2'h2,
    MODE_SPLIT = 2'h3
  } dtc_mode_t;

  typedef struct packed {
    logic gate_enable_b;
    logic count_sel_b;
    dtc_mode_t mode_b;
    logic gate_enable_a;
    logic count_sel_a;
    dtc_mode_t mode_a;
  } dtc_mode_sel_t;

  typedef struct packed {
    logic overflow_flag_b;
    logic run_bit_b;
    logic overflow_flag_a;
    logic run_bit_a;
    logic ext_irq_flag_b;
    logic ext_irq_type_b;
    logic ext_irq_flag_a;
    logic ext_irq_type_a;
  } dtc_irq_ctrl_t;

  // flag bundle: used both for vector acknowledges and flag outputs
  typedef struct packed {
    logic overflow_b;
    logic overflow_a;
    logic ext_b;
    logic ext_a;
  } dtc_irq_t;

endpackage : dtc_pkg

// ### logic/dtc_top.sv
// dual timer/counter with external interrupt flags and apb registers
`timescale 1ns/10ps

// Behaviour
// [R1] timer B counts when run, gated by pin
// [R2] timer A gated likewise with own bits
// [R3] select bit picks prescaled clock or pin
// [R4] B mode: 13-bit, 16-bit, reload, off
// [R5] A mode 11 splits into two counters
// [R6] B overflow sets flag, vector clears it
// [R7] A overflow sets flag, vector clears it
// [R8] run bit disables or enables each timer
// [R9] B edge mode: falling edge sets flag
// [R10] B level mode: flag follows low pin
// [R11] A edge mode: falling edge sets flag
// [R12] A level mode: flag follows low pin
// [R13] type bit: 0 level, 1 falling edge
// [R14] rate bit: divide 12 or 4, timer only
// [R15] stretch field resets to 001, writable
// [R16] 13-bit counter from low5 and high8
// [R17] 13-bit wraps past 1FFF, sets flag
// [R18] software masks undetermined low-byte top bits
// [R19] timeout scales with divider and count
// [R20] 16-bit mode overflows from FFFF
// [R21] reload mode copies high into low
// [R22] split high byte uses B run, flag
// [R23] split with B mode 3 holds B
// [R24] count pins synchronised, falling edge counts
module dtc_top #(
  parameter int unsigned ADDR_W = 12
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [dtc_pkg::DATA_W-1:0] PWDATA_I,
  output logic [dtc_pkg::DATA_W-1:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // external pins
  input wire logic COUNT_PIN_A_I,
  input wire logic COUNT_PIN_B_I,
  input wire logic EXT_IRQ_PIN_A_I,
  input wire logic EXT_IRQ_PIN_B_I,
  // interrupt controller side
  input wire dtc_pkg::dtc_irq_t VECTOR_ACK_I,
  output dtc_pkg::dtc_irq_t IRQ_FLAGS_O,
  // external memory interface setting
  output logic [2:0] RAM_STRETCH_O
);
  import dtc_pkg::*;

  // reset release synchroniser
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // pin synchronisers and falling-edge detect
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_meta_r;
  logic [PIN_N-1:0] pin_sync_r;
  logic [PIN_N-1:0] pin_prev_r;
  logic [PIN_N-1:0] pin_fall;

  assign pin_raw = {COUNT_PIN_B_I, COUNT_PIN_A_I,
                    EXT_IRQ_PIN_B_I, EXT_IRQ_PIN_A_I};

  for (genvar i = 0; i < PIN_N; i++) begin : g_pin
    always_ff @(posedge CLK_SYS_I or negedge rst_n_r) begin
      if (!rst_n_r) begin
        pin_meta_r[i] <= 1'b1;
        pin_sync_r[i] <= 1'b1;
        pin_prev_r[i] <= 1'b1;
      end else begin
        pin_meta_r[i] <= pin_raw[i]; // R24
        pin_sync_r[i] <= pin_meta_r[i];
        pin_prev_r[i] <= pin_sync_r[i];
      end
    end
    assign pin_fall[i] = pin_prev_r[i] & ~pin_sync_r[i]; // R24
  end

  // prescaler: one shared divide-by-12 counter gives both rates
  logic [PRESC_W-1:0] presc_r;
  logic [PRESC_W-1:0] presc_nxt;
  logic tick_slow;
  logic tick_fast;

  always_comb begin
    if (presc_r == DIV_SLOW - 4'h1) begin
      presc_nxt = '0;
    end else begin
      presc_nxt = presc_r + 4'h1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_nxt;
    end
  end

  // one tick per 12 or per 4 cpu clocks sets the timeout scale
  assign tick_slow = (presc_r == DIV_SLOW - 4'h1); // R19
  assign tick_fast = (presc_r[1:0] == 2'(DIV_FAST - 4'h1)); // R19

  // registers
  dtc_irq_ctrl_t ctrl_r;
  dtc_irq_ctrl_t ctrl_nxt;
  dtc_mode_sel_t msel_r;
  dtc_mode_sel_t msel_nxt;
  logic [CLK_RATE_W-1:0] rate_r;
  logic [CLK_RATE_W-1:0] rate_nxt;
  logic [REG_W-1:0] lo_a_r;
  logic [REG_W-1:0] hi_a_r;
  logic [REG_W-1:0] lo_b_r;
  logic [REG_W-1:0] hi_b_r;
  logic [REG_W-1:0] lo_a_nxt;
  logic [REG_W-1:0] hi_a_nxt;
  logic [REG_W-1:0] lo_b_nxt;
  logic [REG_W-1:0] hi_b_nxt;

  // bus decode
  logic [IDX_W-1:0] idx;
  logic addr_hit;
  logic wr_en;
  logic setup;
  logic [REG_W-1:0] wdata;

  assign idx = PADDR_I[IDX_LSB +: IDX_W];
  assign wdata = PWDATA_I[REG_W-1:0];
  assign setup = PSEL_I & ~PENABLE_I;
  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I & addr_hit;

  always_comb begin
    addr_hit = 1'b0;
    if (PADDR_I[ADDR_W-1:IDX_LSB+IDX_W] == '0 &&
        idx >= IDX_IRQ_CTRL && idx <= IDX_CLK_RATE) begin
      addr_hit = 1'b1;
    end
  end

  // one increment step for the selected mode: {carry, high, low}
  function automatic logic [16:0] cnt_step(
    input dtc_mode_t mode,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    s13 = {1'b0, hi, lo[CNT13_LO_W-1:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8 = {1'b0, lo} + 9'h001;
    case (mode)
      MODE_13BIT: begin
        // top three low-byte bits are left as they are
        cnt_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]}; // R16 R17
      end
      MODE_16BIT: begin
        cnt_step = s16; // R20
      end
      MODE_8RELOAD: begin
        cnt_step = {s8[8], hi, s8[8] ? hi : s8[7:0]}; // R21
      end
      default: begin
        cnt_step = {s8[8], hi, s8[7:0]};
      end
    endcase
  endfunction : cnt_step

  // count enables and ticks
  logic split_a;
  logic src_a;
  logic src_b;
  logic src_hi_a;
  logic run_a;
  logic run_b;
  logic run_hi_a;
  logic inc_a;
  logic inc_b;
  logic inc_hi_a;
  logic [16:0] step_a;
  logic [16:0] step_b;
  logic [8:0] step_hi_a;
  logic ovf_a_evt;
  logic ovf_b_evt;

  assign split_a = (msel_r.mode_a == MODE_SPLIT); // R5

  always_comb begin
    // prescaled clock or pin transitions; rate bit ignored for pins
    src_a = msel_r.count_sel_a ? pin_fall[PIN_CNT_A] // R3 R24
          : (rate_r[RATE_A_BIT] ? tick_fast : tick_slow); // R14
    src_b = msel_r.count_sel_b ? pin_fall[PIN_CNT_B] // R3 R24
          : (rate_r[RATE_B_BIT] ? tick_fast : tick_slow); // R14
    // split high byte is always a timer on the b rate bit
    src_hi_a = rate_r[RATE_B_BIT] ? tick_fast : tick_slow; // R22
    run_a = ctrl_r.run_bit_a & // R8
            (~msel_r.gate_enable_a | pin_sync_r[PIN_IRQ_A]); // R2
    if (msel_r.mode_b == MODE_SPLIT) begin
      run_b = 1'b0; // R4 R23
    end else if (split_a) begin
      // run bit b belongs to the split high byte; mode bits switch b
      run_b = ~msel_r.gate_enable_b | pin_sync_r[PIN_IRQ_B];
    end else begin
      run_b = ctrl_r.run_bit_b & // R8
              (~msel_r.gate_enable_b | pin_sync_r[PIN_IRQ_B]); // R1
    end
    run_hi_a = split_a & ctrl_r.run_bit_b; // R22
    inc_a = run_a & src_a;
    inc_b = run_b & src_b;
    inc_hi_a = run_hi_a & src_hi_a;
    step_a = cnt_step(msel_r.mode_a, lo_a_r, hi_a_r);
    step_b = cnt_step(msel_r.mode_b, lo_b_r, hi_b_r);
    step_hi_a = {1'b0, hi_a_r} + 9'h001;
    ovf_a_evt = inc_a & step_a[16];
    // in split mode flag b comes from the high byte of timer a
    ovf_b_evt = split_a ? (inc_hi_a & step_hi_a[8]) // R22
              : (inc_b & step_b[16]);
  end

  // count registers: a bus write to a byte wins over counting there
  always_comb begin
    lo_a_nxt = lo_a_r;
    hi_a_nxt = hi_a_r;
    lo_b_nxt = lo_b_r;
    hi_b_nxt = hi_b_r;
    if (inc_a) begin
      lo_a_nxt = step_a[7:0];
      if (!split_a) begin
        hi_a_nxt = step_a[15:8];
      end
    end
    if (inc_hi_a) begin
      hi_a_nxt = step_hi_a[7:0]; // R22
    end
    if (inc_b) begin
      lo_b_nxt = step_b[7:0];
      hi_b_nxt = step_b[15:8];
    end
    if (wr_en) begin
      case (idx)
        IDX_CNT_LO_A: lo_a_nxt = wdata;
        IDX_CNT_HI_A: hi_a_nxt = wdata;
        IDX_CNT_LO_B: lo_b_nxt = wdata;
        IDX_CNT_HI_B: hi_b_nxt = wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lo_a_r <= CNT_RST;
      hi_a_r <= CNT_RST;
      lo_b_r <= CNT_RST;
      hi_b_r <= CNT_RST;
    end else begin
      lo_a_r <= lo_a_nxt;
      hi_a_r <= hi_a_nxt;
      lo_b_r <= lo_b_nxt;
      hi_b_r <= hi_b_nxt;
    end
  end

  // control registers; hardware set beats vector clear beats software
  dtc_irq_ctrl_t wctrl;

  assign wctrl = dtc_irq_ctrl_t'(wdata);

  always_comb begin
    ctrl_nxt = ctrl_r;
    msel_nxt = msel_r;
    rate_nxt = rate_r;
    if (wr_en && idx == IDX_IRQ_CTRL) begin
      ctrl_nxt = wctrl;
    end
    if (wr_en && idx == IDX_MODE_SEL) begin
      msel_nxt = dtc_mode_sel_t'(wdata);
    end
    if (wr_en && idx == IDX_CLK_RATE) begin
      rate_nxt = wdata[CLK_RATE_W-1:0]; // R15
    end
    if (VECTOR_ACK_I.overflow_b) begin
      ctrl_nxt.overflow_flag_b = 1'b0; // R6
    end
    if (VECTOR_ACK_I.overflow_a) begin
      ctrl_nxt.overflow_flag_a = 1'b0; // R7
    end
    if (ovf_b_evt) begin
      ctrl_nxt.overflow_flag_b = 1'b1; // R6 R17
    end
    if (ovf_a_evt) begin
      ctrl_nxt.overflow_flag_a = 1'b1; // R7 R17
    end
    // external flag b
    if (ctrl_r.ext_irq_type_b) begin // R13
      if (VECTOR_ACK_I.ext_b) begin
        ctrl_nxt.ext_irq_flag_b = 1'b0; // R9
      end
      if (pin_fall[PIN_IRQ_B]) begin
        ctrl_nxt.ext_irq_flag_b = 1'b1; // R9
      end
    end else begin
      ctrl_nxt.ext_irq_flag_b = ~pin_sync_r[PIN_IRQ_B]; // R10
    end
    // external flag a
    if (ctrl_r.ext_irq_type_a) begin // R13
      if (VECTOR_ACK_I.ext_a) begin
        ctrl_nxt.ext_irq_flag_a = 1'b0; // R11
      end
      if (pin_fall[PIN_IRQ_A]) begin
        ctrl_nxt.ext_irq_flag_a = 1'b1; // R11
      end
    end else begin
      ctrl_nxt.ext_irq_flag_a = ~pin_sync_r[PIN_IRQ_A]; // R12
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= dtc_irq_ctrl_t'(IRQ_CTRL_RST);
      msel_r <= dtc_mode_sel_t'(MODE_SEL_RST);
      rate_r <= {2'h0, RAM_STRETCH_RST}; // R15
    end else begin
      ctrl_r <= ctrl_nxt;
      msel_r <= msel_nxt;
      rate_r <= rate_nxt;
    end
  end

  // read data is captured in the setup cycle; zero wait states
  logic [REG_W-1:0] rd_sel;
  logic [DATA_W-1:0] prdata_r;
  logic [DATA_W-1:0] prdata_nxt;
  logic slverr_r;
  logic slverr_nxt;

  always_comb begin
    case (idx)
      IDX_IRQ_CTRL: rd_sel = ctrl_r;
      IDX_MODE_SEL: rd_sel = msel_r;
      IDX_CNT_LO_A: rd_sel = lo_a_r;
      IDX_CNT_LO_B: rd_sel = lo_b_r;
      IDX_CNT_HI_A: rd_sel = hi_a_r;
      IDX_CNT_HI_B: rd_sel = hi_b_r;
      IDX_CLK_RATE: rd_sel = {3'h0, rate_r};
      default: rd_sel = '0;
    endcase
    prdata_nxt = prdata_r;
    slverr_nxt = slverr_r;
    if (setup) begin
      prdata_nxt = (addr_hit && !PWRITE_I) ? {24'h0, rd_sel} : '0;
      slverr_nxt = ~addr_hit;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prdata_r <= '0;
      slverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  assign PRDATA_O = prdata_r;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & slverr_r;

  assign IRQ_FLAGS_O = '{overflow_b: ctrl_r.overflow_flag_b,
                         overflow_a: ctrl_r.overflow_flag_a,
                         ext_b: ctrl_r.ext_irq_flag_b,
                         ext_a: ctrl_r.ext_irq_flag_a};
  assign RAM_STRETCH_O = rate_r[STRETCH_MSB:0]; // R15

endmodule : dtc_top

// ### verif/dtc_asserts.sv
// assertions on the timer/counter control ports
`timescale 1ns/10ps
module dtc_asserts #(
  parameter int unsigned ADDR_W = 12
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  // apb
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [dtc_pkg::DATA_W-1:0] PWDATA_I,
  input wire logic [dtc_pkg::DATA_W-1:0] PRDATA_O,
  // pins and flags
  input wire logic EXT_IRQ_PIN_A_I,
  input wire logic EXT_IRQ_PIN_B_I,
  input wire dtc_pkg::dtc_irq_t VECTOR_ACK_I,
  input wire dtc_pkg::dtc_irq_t IRQ_FLAGS_O,
  input wire logic [2:0] RAM_STRETCH_O
);
  import dtc_pkg::*;
  localparam logic [ADDR_W-1:0] A_IRQ = ADDR_W'({IDX_IRQ_CTRL, 2'h0});
  localparam logic [ADDR_W-1:0] A_MODE = ADDR_W'({IDX_MODE_SEL, 2'h0});
  localparam logic [ADDR_W-1:0] A_RATE = ADDR_W'({IDX_CLK_RATE, 2'h0});
  logic acc;
  logic wr_irq;
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic [1:0] typ_r;
  logic [1:0] typ_nxt;
  assign acc = PSEL_I && PENABLE_I;
  assign wr_irq = acc && PWRITE_I && PADDR_I == A_IRQ;
  // shadow of the mode register and the two trigger type bits {b, a}
  always_comb begin
    mode_nxt = mode_r;
    typ_nxt = typ_r;
    if (acc && PWRITE_I && PADDR_I == A_MODE) begin
      mode_nxt = PWDATA_I[7:0];
    end
    if (wr_irq) begin
      typ_nxt = {PWDATA_I[2], PWDATA_I[0]};
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mode_r <= 8'h00;
      typ_r <= 2'h0;
    end else begin
      mode_r <= mode_nxt;
      typ_r <= typ_nxt;
    end
  end
  default clocking dc @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_B_I);
  stretch_rst_a:
    assert property ($rose(RST_B_I) |-> RAM_STRETCH_O == 3'h1)
    else $error("stretch field wrong after reset");
  stretch_wr_a:
    assert property (acc && PWRITE_I && PADDR_I == A_RATE
      |=> RAM_STRETCH_O == $past(PWDATA_I[2:0]))
    else $error("stretch field not written");
  mode_rd_a:
    assert property (acc && !PWRITE_I && PADDR_I == A_MODE
      |-> PRDATA_O == {24'h0, mode_r})
    else $error("mode register readback wrong");
  type_rd_a:
    assert property (acc && !PWRITE_I && PADDR_I == A_IRQ
      |-> {PRDATA_O[2], PRDATA_O[0]} == typ_r)
    else $error("trigger type bits wrong");
  level_low_a:
    assert property ((!typ_r[0] && !EXT_IRQ_PIN_A_I)[*6]
      |-> IRQ_FLAGS_O.ext_a)
    else $error("level flag a not set by low pin");
  level_high_a:
    assert property ((!typ_r[1] && EXT_IRQ_PIN_B_I)[*6]
      |-> !IRQ_FLAGS_O.ext_b)
    else $error("level flag b not clear on high pin");
  edge_set_a:
    assert property (typ_r[0] && $fell(EXT_IRQ_PIN_A_I)
      |-> ##[1:5] IRQ_FLAGS_O.ext_a)
    else $error("falling edge did not set flag a");
  ack_clear_a:
    assert property ((typ_r[1] && EXT_IRQ_PIN_B_I)[*5]
      ##0 (VECTOR_ACK_I.ext_b && !wr_irq) |=> !IRQ_FLAGS_O.ext_b)
    else $error("vector ack did not clear flag b");
  cover property (IRQ_FLAGS_O.overflow_a);
  cover property (IRQ_FLAGS_O.overflow_b);
  cover property (VECTOR_ACK_I.ext_b ##1 !IRQ_FLAGS_O.ext_b);
endmodule : dtc_asserts

bind dtc_top dtc_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .CLK_SYS_I(CLK_SYS_I),
  .RST_B_I(RST_B_I),
  .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O),
  .EXT_IRQ_PIN_A_I(EXT_IRQ_PIN_A_I),
  .EXT_IRQ_PIN_B_I(EXT_IRQ_PIN_B_I),
  .VECTOR_ACK_I(VECTOR_ACK_I),
  .IRQ_FLAGS_O(IRQ_FLAGS_O),
  .RAM_STRETCH_O(RAM_STRETCH_O)
);

// ### verif/dtc_pins.sv
// pin-side model: count inputs and interrupt request lines
`timescale 1ns/10ps
module dtc_pins (
  // clock
  input wire logic clk_i,
  // pin levels, indexed by the package pin positions
  output logic [3:0] pins_o
);
  // idle high so no false falling edge appears at start
  initial pins_o = 4'hF;
  task automatic drive(input int p, input logic v, input int c);
    pins_o[p] <= v;
    repeat (c) @(posedge clk_i);
  endtask : drive
  // each level held three cycles so the synchroniser sees it
  task automatic pulses(input int p, input int c);
    repeat (c) begin
      drive(p, 1'b0, 3);
      drive(p, 1'b1, 3);
    end
  endtask : pulses
endmodule : dtc_pins

// ### verif/dual_timer_counter_control_tb_top.sv
// self-checking bench for the dual timer/counter control block
`timescale 1ns/10ps
module dual_timer_counter_control_tb_top;
  import dtc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] pin;
  dtc_irq_t ack = 4'h0;
  dtc_irq_t flags;
  logic [2:0] stretch;
  logic [31:0] rd;
  logic err_r;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  always #12.5 clk = ~clk;
  dtc_pins pins (.clk_i(clk), .pins_o(pin));
  dtc_top dut (
    .CLK_SYS_I(clk),
    .RST_B_I(rst_b),
    .PSEL_I(psel),
    .PENABLE_I(penable),
    .PWRITE_I(pwrite),
    .PADDR_I(paddr),
    .PWDATA_I(pwdata),
    .PRDATA_O(prdata),
    .PREADY_O(pready),
    .PSLVERR_O(pslverr),
    .COUNT_PIN_A_I(pin[PIN_CNT_A]),
    .COUNT_PIN_B_I(pin[PIN_CNT_B]),
    .EXT_IRQ_PIN_A_I(pin[PIN_IRQ_A]),
    .EXT_IRQ_PIN_B_I(pin[PIN_IRQ_B]),
    .VECTOR_ACK_I(ack),
    .IRQ_FLAGS_O(flags),
    .RAM_STRETCH_O(stretch)
  );
  task automatic report_and_stop();
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err_r = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask : rdc
  task automatic ack_p(input logic [3:0] m);
    ack <= m;
    @(posedge clk);
    ack <= 4'h0;
    @(posedge clk);
  endtask : ack_p
  task automatic wf(input int b);
    n = 0;
    while (flags[b] !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask : wf
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      rdc(IDX_IRQ_CTRL + 8'(i), (i == 6) ? 32'h1 : 32'h0);
    end
    apb(1'b0, 8'h8F, 8'h00);
    chk({rd[31:1], err_r}, 32'h1);
    wr(IDX_MODE_SEL, 8'hA5);
    rdc(IDX_MODE_SEL, 32'hA5);
    wr(IDX_CLK_RATE, 8'hFF);
    rdc(IDX_CLK_RATE, 32'h1F);
    chk({29'h0, stretch}, 32'h7);
    // reload counter on pin a
    wr(IDX_MODE_SEL, 8'h06);
    wr(IDX_CNT_HI_A, 8'hFE);
    wr(IDX_CNT_LO_A, 8'hFE);
    wr(IDX_IRQ_CTRL, 8'h10);
    pins.pulses(PIN_CNT_A, 1);
    rdc(IDX_CNT_LO_A, 32'hFF);
    pins.pulses(PIN_CNT_A, 1);
    rdc(IDX_CNT_LO_A, 32'hFE);
    chk({28'h0, flags}, 32'h4);
    ack_p(4'h4);
    chk({28'h0, flags}, 32'h0);
    wr(IDX_IRQ_CTRL, 8'h00);
    pins.pulses(PIN_CNT_A, 2);
    rdc(IDX_CNT_LO_A, 32'hFE);
    // overflow period at both prescaler rates
    for (int f = 0; f < 2; f++) begin
      wr(IDX_IRQ_CTRL, 8'h00);
      wr(IDX_CLK_RATE, f[0] ? 8'h08 : 8'h00);
      wr(IDX_MODE_SEL, 8'h02);
      wr(IDX_CNT_HI_A, 8'hF0);
      wr(IDX_CNT_LO_A, 8'hF0);
      wr(IDX_IRQ_CTRL, 8'h10);
      wf(2);
      ack_p(4'h4);
      wf(2);
      chk(n + 2, f[0] ? 32'd64 : 32'd192);
    end
    // 13-bit wrap
    wr(IDX_IRQ_CTRL, 8'h00);
    wr(IDX_MODE_SEL, 8'h00);
    wr(IDX_CLK_RATE, 8'h00);
    wr(IDX_CNT_HI_A, 8'hFF);
    wr(IDX_CNT_LO_A, 8'hFF);
    wr(IDX_IRQ_CTRL, 8'h10);
    wf(2);
    chk({28'h0, flags}, 32'h4);
    wr(IDX_IRQ_CTRL, 8'h00);
    apb(1'b0, IDX_CNT_LO_A, 8'h00);
    chk(rd & 32'h1F, 32'h0);
    rdc(IDX_CNT_HI_A, 32'h0);
    // gated 16-bit counter on pin b
    wr(IDX_MODE_SEL, 8'hD0);
    wr(IDX_CNT_LO_B, 8'hFF);
    wr(IDX_CNT_HI_B, 8'hFF);
    wr(IDX_IRQ_CTRL, 8'h40);
    pins.drive(PIN_IRQ_B, 1'b0, 8);
    chk({28'h0, flags}, 32'h2);
    pins.pulses(PIN_CNT_B, 1);
    rdc(IDX_CNT_LO_B, 32'hFF);
    pins.drive(PIN_IRQ_B, 1'b1, 6);
    pins.pulses(PIN_CNT_B, 1);
    rdc(IDX_CNT_HI_B, 32'h0);
    chk({28'h0, flags}, 32'h8);
    ack_p(4'h8);
    chk({28'h0, flags}, 32'h0);
    // edge and level triggering
    wr(IDX_IRQ_CTRL, 8'h05);
    pins.drive(PIN_IRQ_A, 1'b0, 6);
    chk({28'h0, flags}, 32'h1);
    pins.drive(PIN_IRQ_A, 1'b1, 3);
    ack_p(4'h1);
    chk({28'h0, flags}, 32'h0);
    wr(IDX_IRQ_CTRL, 8'h0F);
    chk({28'h0, flags}, 32'h3);
    ack_p(4'h2);
    chk({28'h0, flags}, 32'h1);
    // enter level mode first so the flag write below meets level mode
    wr(IDX_IRQ_CTRL, 8'h00);
    wr(IDX_IRQ_CTRL, 8'h0A);
    chk({28'h0, flags}, 32'h0);
    pins.drive(PIN_IRQ_A, 1'b0, 8);
    wr(IDX_IRQ_CTRL, 8'h00);
    chk({28'h0, flags}, 32'h1);
    pins.drive(PIN_IRQ_A, 1'b1, 6);
    // split mode
    wr(IDX_MODE_SEL, 8'h33);
    wr(IDX_CLK_RATE, 8'h10);
    wr(IDX_CNT_HI_A, 8'hFE);
    wr(IDX_CNT_LO_B, 8'h55);
    wr(IDX_IRQ_CTRL, 8'h40);
    wf(3);
    chk({28'h0, flags}, 32'h8);
    wr(IDX_IRQ_CTRL, 8'h00);
    rdc(IDX_CNT_LO_B, 32'h55);
    report_and_stop();
  end
endmodule : dual_timer_counter_control_tb_top
